// *** rtl/stap_top.sv ***
// scan test access port pin logic: synchronisers, edge finding, ir/dr scan, pin mux defaults
// assumes clk is much faster than the debugger's tck; all pins are asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
`include "stap_defines.svh"

// Summary of operation
// - test reset high gives the scan system control of the device.
// - test reset low or floating keeps functional mode, scan signalling ignored.
// - mode select is sampled into the tap controller on tck rising edges.
// - test data in is captured into the selected register on tck rising edges.
// - the selected register is shifted out on test data out at tck falling edges.
// - after reset test port pins take their test function, others general io.
module stap_top #(
   parameter logic [`STAP_DR_W-1:0] IDCODE_VALUE = 32'h0000_0001  // arbitrary value
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic trst,
   output logic tdo,
   output logic tdo_oe,
   output logic scan_owner,
   input wire logic [`STAP_USER_W-1:0] user_capture,
   output logic [`STAP_USER_W-1:0] user_update,
   input wire logic mux_wr,
   input wire logic mux_jtag_val,
   input wire logic [`STAP_GPIO_N-1:0] mux_gpio_val,
   output logic jtag_pin_sel,
   output logic [`STAP_GPIO_N-1:0] gpio_pin_sel
);

   stap_pkg::stap_top_type r_reg;
   stap_pkg::stap_top_type r_next;
   stap_tap_if tap_bus ();

   logic [`STAP_PIN_COUNT-1:0] pins;
   logic [`STAP_PIN_COUNT-1:0] agree;
   logic tck_rise;
   logic tck_fall;
   logic tms_s;
   logic tdi_s;
   logic trst_on;

   // ***********************************************************************
   // data register decode
   // ***********************************************************************
   // length of the data register that an instruction selects; unknown codes act as bypass
   function automatic int unsigned dr_len(input logic [`STAP_IR_W-1:0] ir);
      int unsigned n;
      n = 1;
      if (ir == `STAP_IR_IDCODE) begin
         n = `STAP_DR_W;
      end else if (ir == `STAP_IR_USER) begin
         n = `STAP_USER_W;
      end
      return n;
   endfunction : dr_len

   // shift right by one, new bit entering at the top of the selected length
   function automatic logic [`STAP_DR_W-1:0] dr_shift(
      input logic [`STAP_DR_W-1:0] sh,
      input logic din,
      input logic [`STAP_IR_W-1:0] ir
   );
      logic [`STAP_DR_W-1:0] v;
      int unsigned len;
      v = sh >> 1;
      len = dr_len(ir);
      v[len-1] = din;
      return v;
   endfunction : dr_shift

   // ***********************************************************************
   // pin sampling
   // ***********************************************************************
   always_comb begin
      pins = '0;
      pins[`STAP_PIN_TCK] = tck;
      pins[`STAP_PIN_TMS] = tms;
      pins[`STAP_PIN_TDI] = tdi;
      pins[`STAP_PIN_TRST] = trst;
   end

   // a level counts once stages two and three agree; stage one feeds only stage two
   always_comb begin
      for (int i = 0; i < `STAP_PIN_COUNT; i++) begin
         agree[i] = (r_reg.stg2[i] == r_reg.stg3[i]);
      end
   end

   // tms and tdi ride the same pipeline as tck, so they are taken at the edge they set up for
   assign tck_rise = agree[`STAP_PIN_TCK] & r_reg.stg2[`STAP_PIN_TCK] & ~r_reg.filt[`STAP_PIN_TCK];
   assign tck_fall = agree[`STAP_PIN_TCK] & ~r_reg.stg2[`STAP_PIN_TCK] & r_reg.filt[`STAP_PIN_TCK];
   assign tms_s = agree[`STAP_PIN_TMS] ? r_reg.stg2[`STAP_PIN_TMS] : r_reg.filt[`STAP_PIN_TMS];
   assign tdi_s = agree[`STAP_PIN_TDI] ? r_reg.stg2[`STAP_PIN_TDI] : r_reg.filt[`STAP_PIN_TDI];
   assign trst_on = r_reg.filt[`STAP_PIN_TRST];         // active high

   // ***********************************************************************
   // tap controller
   // ***********************************************************************
   assign tap_bus.step = tck_rise;
   assign tap_bus.tms = tms_s;
   assign tap_bus.hold_rst = ~trst_on;

   stap_tap_fsm u_fsm (
      .clk(clk),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .tap(tap_bus.fsm)
   );

   // ***********************************************************************
   // scan registers and pin mux
   // ***********************************************************************
   always_comb begin
      r_next = r_reg;
      r_next.stg1 = pins;
      r_next.stg2 = r_reg.stg1;
      r_next.stg3 = r_reg.stg2;
      for (int i = 0; i < `STAP_PIN_COUNT; i++) begin
         if (agree[i]) begin
            r_next.filt[i] = r_reg.stg2[i];
         end
      end
      // pin mux changes come from device logic on clk; scan activity never touches it
      if (mux_wr) begin
         r_next.jtag_sel = mux_jtag_val;
         r_next.gpio_sel = mux_gpio_val;
      end
      if (!trst_on) begin
         // functional mode: scan state parked, output released
         r_next.ir = `STAP_IR_IDCODE;
         r_next.tdo_oe = 1'b0;
      end else begin
         if (tck_rise) begin
            unique case (tap_bus.state)
               stap_pkg::st_reset: begin
                  r_next.ir = `STAP_IR_IDCODE;
               end
               stap_pkg::st_cap_dr: begin
                  if (r_reg.ir == `STAP_IR_IDCODE) begin
                     r_next.dr_sh = IDCODE_VALUE;
                  end else if (r_reg.ir == `STAP_IR_USER) begin
                     r_next.dr_sh = {{(`STAP_DR_W-`STAP_USER_W){1'b0}}, user_capture};
                  end else begin
                     r_next.dr_sh = '0;
                  end
               end
               stap_pkg::st_sh_dr: begin
                  r_next.dr_sh = dr_shift(r_reg.dr_sh, tdi_s, r_reg.ir);
               end
               stap_pkg::st_upd_dr: begin
                  if (r_reg.ir == `STAP_IR_USER) begin
                     r_next.user_upd = r_reg.dr_sh[`STAP_USER_W-1:0];
                  end
               end
               stap_pkg::st_cap_ir: begin
                  r_next.ir_sh = `STAP_IR_CAPTURE;
               end
               stap_pkg::st_sh_ir: begin
                  r_next.ir_sh = {tdi_s, r_reg.ir_sh[`STAP_IR_W-1:1]};
               end
               stap_pkg::st_upd_ir: begin
                  r_next.ir = r_reg.ir_sh;
               end
               default: begin
               end
            endcase
         end
         // output moves only on falling edges so the debugger samples a settled bit
         if (tck_fall) begin
            if (tap_bus.state == stap_pkg::st_sh_ir) begin
               r_next.tdo = r_reg.ir_sh[0];
               r_next.tdo_oe = 1'b1;
            end else if (tap_bus.state == stap_pkg::st_sh_dr) begin
               r_next.tdo = r_reg.dr_sh[0];
               r_next.tdo_oe = 1'b1;
            end else begin
               r_next.tdo_oe = 1'b0;
            end
         end
      end
   end

   // ***********************************************************************
   // state register
   // ***********************************************************************
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         r_reg <= '{stg1: '0, stg2: '0, stg3: '0, filt: '0,
                    ir: `STAP_IR_IDCODE, ir_sh: '0, dr_sh: '0,
                    user_upd: `STAP_RST_USER, tdo: 1'b0, tdo_oe: 1'b0,
                    jtag_sel: `STAP_RST_JTAG_SEL,
                    gpio_sel: `STAP_RST_GPIO_SEL};
      end else if (clk_en) begin
         r_reg <= r_next;
      end
   end

   // outputs straight from flip-flops
   assign tdo = r_reg.tdo;
   assign tdo_oe = r_reg.tdo_oe;
   assign scan_owner = trst_on;
   assign user_update = r_reg.user_upd;
   assign jtag_pin_sel = r_reg.jtag_sel;
   assign gpio_pin_sel = r_reg.gpio_sel;

endmodule : stap_top

`default_nettype wire

// *** rtl/stap_defines.svh ***
// constants of the scan test access block: pin slots, widths, codes, reset values
// assumes inclusion by bare name from the package and the design modules
`ifndef STAP_DEFINES_SVH
`define STAP_DEFINES_SVH

// slots of the synchronised pin vector
`define STAP_PIN_TCK 0
`define STAP_PIN_TMS 1
`define STAP_PIN_TDI 2
`define STAP_PIN_TRST 3
`define STAP_PIN_COUNT 4

// register widths
`define STAP_IR_W 4
`define STAP_DR_W 32
`define STAP_USER_W 8
`define STAP_GPIO_N 8

// instruction codes and the fixed capture pattern
`define STAP_IR_IDCODE 4'h1
`define STAP_IR_USER 4'h2
`define STAP_IR_BYPASS 4'hf
`define STAP_IR_CAPTURE 4'h1

// reset values
`define STAP_RST_JTAG_SEL 1'h1
`define STAP_RST_GPIO_SEL 8'h00
`define STAP_RST_USER 8'h00

`endif

// *** rtl/stap_pkg.sv ***
// types shared by the scan test access block
// assumes stap_defines.svh is on the include path
`default_nettype none
`include "stap_defines.svh"

package stap_pkg;

   // standard sixteen-state tap controller
   typedef enum logic [3:0] {
      st_reset, st_idle, st_sel_dr, st_cap_dr, st_sh_dr, st_ex1_dr, st_pa_dr, st_ex2_dr,
      st_upd_dr, st_sel_ir, st_cap_ir, st_sh_ir, st_ex1_ir, st_pa_ir, st_ex2_ir, st_upd_ir
   } stap_tap_state_type;

   // state of the controller module
   typedef struct packed {
      stap_tap_state_type state;
   } stap_fsm_type;

   // state of the top module
   typedef struct packed {
      logic [`STAP_PIN_COUNT-1:0] stg1;
      logic [`STAP_PIN_COUNT-1:0] stg2;
      logic [`STAP_PIN_COUNT-1:0] stg3;
      logic [`STAP_PIN_COUNT-1:0] filt;
      logic [`STAP_IR_W-1:0] ir;
      logic [`STAP_IR_W-1:0] ir_sh;
      logic [`STAP_DR_W-1:0] dr_sh;
      logic [`STAP_USER_W-1:0] user_upd;
      logic tdo;
      logic tdo_oe;
      logic jtag_sel;
      logic [`STAP_GPIO_N-1:0] gpio_sel;
   } stap_top_type;

endpackage : stap_pkg

`default_nettype wire

// *** rtl/stap_tap_if.sv ***
// link between the pin front end and the tap controller
// assumes both ends run on the same clk
`timescale 1ns/1ps
`default_nettype none

interface stap_tap_if;
   logic step;                         // one-cycle pulse on a sampled tck rising edge
   logic tms;                          // filtered mode select at that edge
   logic hold_rst;                     // keep the controller in its reset state
   stap_pkg::stap_tap_state_type state;

   modport fsm (input step, input tms, input hold_rst, output state);
   modport front (output step, output tms, output hold_rst, input state);
endinterface : stap_tap_if

`default_nettype wire

// *** rtl/stap_tap_fsm.sv ***
// tap controller state machine, advanced by sampled tck rising edges
// assumes step and tms come already synchronised to clk
`timescale 1ns/1ps
`default_nettype none

module stap_tap_fsm (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clk_en,
   stap_tap_if.fsm tap
);

   stap_pkg::stap_fsm_type r_reg;
   stap_pkg::stap_fsm_type r_next;

   // ***********************************************************************
   // next state
   // ***********************************************************************
   function automatic stap_pkg::stap_tap_state_type tap_step(
      input stap_pkg::stap_tap_state_type s,
      input logic m
   );
      stap_pkg::stap_tap_state_type t;
      t = s;
      unique case (s)
         stap_pkg::st_reset:  t = m ? stap_pkg::st_reset  : stap_pkg::st_idle;
         stap_pkg::st_idle:   t = m ? stap_pkg::st_sel_dr : stap_pkg::st_idle;
         stap_pkg::st_sel_dr: t = m ? stap_pkg::st_sel_ir : stap_pkg::st_cap_dr;
         stap_pkg::st_cap_dr: t = m ? stap_pkg::st_ex1_dr : stap_pkg::st_sh_dr;
         stap_pkg::st_sh_dr:  t = m ? stap_pkg::st_ex1_dr : stap_pkg::st_sh_dr;
         stap_pkg::st_ex1_dr: t = m ? stap_pkg::st_upd_dr : stap_pkg::st_pa_dr;
         stap_pkg::st_pa_dr:  t = m ? stap_pkg::st_ex2_dr : stap_pkg::st_pa_dr;
         stap_pkg::st_ex2_dr: t = m ? stap_pkg::st_upd_dr : stap_pkg::st_sh_dr;
         stap_pkg::st_upd_dr: t = m ? stap_pkg::st_sel_dr : stap_pkg::st_idle;
         stap_pkg::st_sel_ir: t = m ? stap_pkg::st_reset  : stap_pkg::st_cap_ir;
         stap_pkg::st_cap_ir: t = m ? stap_pkg::st_ex1_ir : stap_pkg::st_sh_ir;
         stap_pkg::st_sh_ir:  t = m ? stap_pkg::st_ex1_ir : stap_pkg::st_sh_ir;
         stap_pkg::st_ex1_ir: t = m ? stap_pkg::st_upd_ir : stap_pkg::st_pa_ir;
         stap_pkg::st_pa_ir:  t = m ? stap_pkg::st_ex2_ir : stap_pkg::st_pa_ir;
         stap_pkg::st_ex2_ir: t = m ? stap_pkg::st_upd_ir : stap_pkg::st_sh_ir;
         stap_pkg::st_upd_ir: t = m ? stap_pkg::st_sel_dr : stap_pkg::st_idle;
      endcase
      return t;
   endfunction : tap_step

   // advance on each sampled rising edge, held in reset while test reset is off
   always_comb begin
      r_next = r_reg;
      if (tap.hold_rst) begin
         r_next.state = stap_pkg::st_reset;
      end else if (tap.step) begin
         r_next.state = tap_step(r_reg.state, tap.tms);
      end
   end

   // ***********************************************************************
   // state register
   // ***********************************************************************
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         r_reg <= '{state: stap_pkg::st_reset};
      end else if (clk_en) begin
         r_reg <= r_next;
      end
   end

   assign tap.state = r_reg.state;

endmodule : stap_tap_fsm

`default_nettype wire

// *** testbench/stap_top_chk.sv ***
// checker of the scan test access pins, bound into stap_top
// assumes tck high and low phases each last at least 3 clk
`timescale 1ns/1ps
`default_nettype none

module stap_top_chk (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic tck,
   input wire logic trst,
   input wire logic tdo,
   input wire logic tdo_oe,
   input wire logic scan_owner,
   input wire logic [7:0] user_update,
   input wire logic mux_wr,
   input wire logic mux_jtag_val,
   input wire logic [7:0] mux_gpio_val,
   input wire logic jtag_pin_sel,
   input wire logic [7:0] gpio_pin_sel
);
   // ****************
   // pin properties
   // ****************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   // the input filter needs a few clk, so seven steady cycles must settle ownership
   chk_owner_on: assert property ((trst && clk_en) [*7] |-> scan_owner)
      else $error("owner low under test reset");
   chk_owner_off: assert property ((!trst && clk_en) [*7] |-> !scan_owner)
      else $error("owner high without test reset");
   chk_oe_owner: assert property (!scan_owner [*8] |-> !tdo_oe)
      else $error("tdo driven without scan ownership");
   // a change seen on a rising tck edge would show tck high in both past samples
   chk_tdo_fall: assert property ($changed(tdo) |-> !$past(tck, 3) || !$past(tck, 4))
      else $error("tdo moved away from a tck fall");
   chk_oe_rise: assert property ($rose(tdo_oe) |-> scan_owner && !$past(tck, 3))
      else $error("tdo enabled off a tck fall");
   chk_mux_load: assert property (mux_wr && clk_en |=> jtag_pin_sel == $past(mux_jtag_val)
         && gpio_pin_sel == $past(mux_gpio_val))
      else $error("pin mux write lost");
   chk_mux_hold: assert property (!(mux_wr && clk_en) |=> $stable({jtag_pin_sel, gpio_pin_sel}))
      else $error("pin mux moved without write");
   chk_pin_defaults: assert property ($rose(reset_n) |-> jtag_pin_sel && gpio_pin_sel == 8'h00)
      else $error("pin mux defaults wrong");
   chk_user_owner: assert property ($changed(user_update) |-> $past(scan_owner))
      else $error("user data updated outside scan");
endmodule : stap_top_chk

bind stap_top stap_top_chk i_chk (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .tck(tck),
   .trst(trst), .tdo(tdo), .tdo_oe(tdo_oe), .scan_owner(scan_owner), .user_update(user_update),
   .mux_wr(mux_wr), .mux_jtag_val(mux_jtag_val), .mux_gpio_val(mux_gpio_val),
   .jtag_pin_sel(jtag_pin_sel), .gpio_pin_sel(gpio_pin_sel));

`default_nettype wire

// *** testbench/stap_dbg_model.sv ***
// debugger model driving the scan link pins with a 320 ns tck
// assumes the caller starts a frame from idle; tck stands low between frames
`timescale 1ns/1ps
`default_nettype none

module stap_dbg_model (
   output logic tck,
   output logic tms,
   output logic tdi,
   output logic trst,
   input wire logic tdo,
   input wire logic tdo_oe
);
   // ****************
   // link driving
   // ****************
   // idle: released mode and data lines sit at their pullup level
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
      trst = 1'b0;
   end

   // test reset stays low unless scan control is wanted
   task automatic own(input logic v);
      trst = v;
   endtask : own

   // pins change with the fall; tdo is read late in the high phase, after its update
   task automatic tick(input logic m, input logic d, output logic o, output logic e);
      tck = 1'b0;
      tms = m;
      tdi = d;
      #160;
      tck = 1'b1;
      #150;
      o = tdo_oe ? tdo : ~tdo; // tdo has no pull, a released line reads as the inverse
      e = tdo_oe;
      #10;
   endtask : tick

   // close a frame: tck stands low, lines released
   task automatic park;
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
   endtask : park

   // five ones reach the reset state, a zero moves to idle
   task automatic tap_reset;
      logic o;
      logic e;
      #13;
      repeat (5) tick(1'b1, 1'b1, o, e);
      tick(1'b0, 1'b1, o, e);
      park();
   endtask : tap_reset

   // capture, shift n bits lsb first, update, back to idle
   task automatic scan(input logic ir, input int n, input logic [31:0] din,
         output logic [31:0] dout, output logic oe);
      logic o;
      logic e;
      dout = 32'h0;
      oe = 1'b0;
      #13;
      tick(1'b1, 1'b1, o, e);
      if (ir) tick(1'b1, 1'b1, o, e);
      tick(1'b0, 1'b1, o, e);
      tick(1'b0, 1'b1, o, e);
      for (int i = 0; i < n; i++) begin
         tick(i == n - 1, din[i], o, e);
         dout[i] = o;
         oe |= e;
      end
      tick(1'b1, 1'b1, o, e);
      tick(1'b0, 1'b1, o, e);
      park();
   endtask : scan
endmodule : stap_dbg_model

`default_nettype wire

// *** testbench/stap_top_tb.sv ***
// self-checking bench of the scan test access pins
// assumes the debugger model drives tck, tms, tdi and test reset
`timescale 1ns/1ps
`default_nettype none

module stap_top_tb;
   localparam logic [31:0] ID = 32'h0a5c_3e71; // arbitrary value
   logic clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, mux_wr = 1'b0, mux_jtag_val = 1'b0;
   logic [7:0] user_capture = 8'h00, mux_gpio_val = 8'h00, user_update, gpio_pin_sel, user_q;
   logic tck, tms, tdi, trst, tdo, tdo_oe, scan_owner, jtag_pin_sel, oe, exp_j;
   logic [7:0] exp_g;
   logic [31:0] got, pat;
   logic [3:0] codes [2] = '{4'hf, 4'h7};
   int num_errors = 0, n_checks = 0;

   // ****************
   // harness
   // ****************
   initial begin
      forever #20 clk = ~clk;
   end

   stap_top #(.IDCODE_VALUE(ID)) i_dut (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
      .tck(tck), .tms(tms), .tdi(tdi), .trst(trst), .tdo(tdo), .tdo_oe(tdo_oe),
      .scan_owner(scan_owner), .user_capture(user_capture), .user_update(user_update),
      .mux_wr(mux_wr), .mux_jtag_val(mux_jtag_val), .mux_gpio_val(mux_gpio_val),
      .jtag_pin_sel(jtag_pin_sel), .gpio_pin_sel(gpio_pin_sel));
   stap_dbg_model i_dbg (.tck(tck), .tms(tms), .tdi(tdi), .trst(trst), .tdo(tdo),
      .tdo_oe(tdo_oe));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // reference data register: len captured bits queued, each shift pops one, pushes one
   function automatic logic [31:0] model_dr(input int len, input logic [31:0] cap,
         input logic [31:0] din, input int n);
      bit q[$];
      logic [31:0] r;
      r = 32'h0;
      for (int i = 0; i < len; i++) q.push_back(cap[i]);
      for (int i = 0; i < n; i++) begin
         r[i] = q.pop_front();
         q.push_back(din[i]);
      end
      return r;
   endfunction : model_dr

   task automatic wrap_up;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : wrap_up

   // bounded wait on the filtered owner flag, then compare
   task automatic wait_owner(input logic v);
      for (int i = 0; i < 20 && scan_owner !== v; i++) @(negedge clk);
      check(scan_owner, v);
   endtask : wait_owner

   // hang guard: a run this long is itself a failure
   initial begin
      repeat (100000) @(posedge clk);
      num_errors++;
      wrap_up();
   end

   // ****************
   // scenarios
   // ****************
   initial begin
      void'($urandom(32'h85e89f5f));
      repeat (3) @(negedge clk);
      check({tdo, tdo_oe, scan_owner, jtag_pin_sel, gpio_pin_sel, user_update}, 20'h10000);
      reset_n = 1'b1;
      // tck traffic without test reset must leave the port silent
      i_dbg.scan(1'b1, 4, 32'h2, got, oe);
      check({scan_owner, oe, user_update}, 10'h000);
      i_dbg.own(1'b1);
      wait_owner(1'b1);
      i_dbg.tap_reset();
      i_dbg.scan(1'b0, 32, 32'h0, got, oe);
      check(got, ID);
      // user register: capture comes out lsb first, shifted-in value lands on update
      repeat (3) begin
         @(negedge clk);
         user_capture = 8'($urandom);
         pat = $urandom;
         i_dbg.scan(1'b1, 4, 32'h2, got, oe);
         check(got, 32'h1);
         i_dbg.scan(1'b0, 8, pat, got, oe);
         user_q = pat[7:0];
         check(got, model_dr(8, {24'h0, user_capture}, pat, 8));
         check(tdo_oe, 1'b0);
         check({oe, user_update}, {1'b1, user_q});
      end
      i_dbg.scan(1'b1, 4, 32'h1, got, oe);
      i_dbg.scan(1'b0, 32, 32'h0, got, oe);
      check(got, ID);
      // bypass and unlisted codes: one-bit register capturing zero
      foreach (codes[k]) begin
         pat = $urandom;
         i_dbg.scan(1'b1, 4, {28'h0, codes[k]}, got, oe);
         i_dbg.scan(1'b0, 8, pat, got, oe);
         check(got, model_dr(1, 32'h0, pat, 8));
      end
      // give control back: ownership drops and scans have no effect
      i_dbg.own(1'b0);
      wait_owner(1'b0);
      i_dbg.scan(1'b0, 8, 32'h5a, got, oe);
      check({oe, user_update}, {1'b0, user_q});
      // pin mux writes, one of them frozen by clk_en
      exp_j = 1'b1;
      exp_g = 8'h00;
      for (int i = 0; i < 4; i++) begin
         @(negedge clk);
         mux_jtag_val = 1'($urandom);
         mux_gpio_val = 8'($urandom);
         clk_en = (i != 2);
         mux_wr = 1'b1;
         if (clk_en) {exp_j, exp_g} = {mux_jtag_val, mux_gpio_val};
         @(negedge clk);
         mux_wr = 1'b0;
         clk_en = 1'b1;
         check({jtag_pin_sel, gpio_pin_sel}, {exp_j, exp_g});
      end
      // reset in mid-run restores the test function on the port pins
      reset_n = 1'b0;
      @(negedge clk);
      check({jtag_pin_sel, gpio_pin_sel, user_update}, 17'h10000);
      reset_n = 1'b1;
      // the first two edges after release must still show the reset values
      repeat (2) begin
         @(negedge clk);
         check({tdo, tdo_oe, scan_owner, jtag_pin_sel, gpio_pin_sel, user_update}, 20'h10000);
      end
      wrap_up();
   end
endmodule : stap_top_tb

`default_nettype wire
